// ---- logic/dfr_consts.svh ----
/*
 holds offsets, field positions, reset values and counts of the dual receiver control block.
 assumes a plain register port with byte-wide locations and one-cycle read latency.
*/
`ifndef DFR_CONSTS_SVH
`define DFR_CONSTS_SVH
// register offsets
`define DFR_OFF_PORTB 4'h0
`define DFR_OFF_PORTC 4'h1
`define DFR_OFF_PORTD 4'h2
`define DFR_OFF_DIRB 4'h3
`define DFR_OFF_DIRC 4'h4
`define DFR_OFF_DIRD 4'h5
// port b fields
`define DFR_B_DEMOD 0
`define DFR_B_SEL_LO 1
`define DFR_B_SEL_HI 3
`define DFR_B_PWDN 7
// port b bits that are stored; the others read as zero or as receiver data
`define DFR_B_KEEP 8'h8e
// port c and d fields
`define DFR_C_DEMOD 0
`define DFR_C_SEL_MSB 3
`define DFR_D_PWDN 0
`define DFR_D_SEL_MID 4
`define DFR_D_SEL_LSB 5
// reset values and channel count
`define DFR_PORT_RST 8'h00
`define DFR_DIR_RST 8'hff
`define DFR_CHAN_COUNT 8
`endif

// ---- logic/dfr_pkg.sv ----
/*
 holds the types of the dual receiver control block.
 assumes nothing of its surroundings.
*/
package dfr_pkg;
  typedef logic [2:0] dfr_chan_type;
  typedef enum logic {DFR_NORMAL, DFR_POWERDOWN} dfr_mode_type;
endpackage : dfr_pkg

// ---- logic/dfr_receiver_ctrl.sv ----
/*
 holds the control-bit logic of two integrated fsk receivers, a and b.
 assumes firmware reaches the port bits over a plain register port, read data one cycle later.
*/
`timescale 1ns/1ps
`include "dfr_consts.svh"
module dfr_receiver_ctrl
  import dfr_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // receiver side
  input wire logic rx_a_demod_in,
  input wire logic rx_b_demod_in,
  output logic [2:0] rx_a_chan_out,
  output logic [2:0] rx_b_chan_out,
  output logic rx_a_powerdown_out,
  output logic rx_b_powerdown_out,
  output logic rx_a_demod_out,
  output logic rx_b_demod_out
);

  // refuse address widths that cannot reach all six locations
  if (ADDR_W < 3) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoding
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  logic [7:0] portb_q, portc_q, portd_q, dirb_q, dirc_q, dird_q;
  logic [7:0] rdata_q;
  dfr_chan_type a_chan_q, b_chan_q;
  logic a_data_q, b_data_q;
  dfr_mode_type a_mode, b_mode;

  wire wr_b = reg_wr_in && hit(reg_addr_in, `DFR_OFF_PORTB);
  wire wr_c = reg_wr_in && hit(reg_addr_in, `DFR_OFF_PORTC);
  wire wr_d = reg_wr_in && hit(reg_addr_in, `DFR_OFF_PORTD);
  wire wr_db = reg_wr_in && hit(reg_addr_in, `DFR_OFF_DIRB);
  wire wr_dc = reg_wr_in && hit(reg_addr_in, `DFR_OFF_DIRC);
  wire wr_dd = reg_wr_in && hit(reg_addr_in, `DFR_OFF_DIRD);

  // reserved port b bits 4..6 read zero; data bits show the receiver outputs
  wire [7:0] portb_view = {portb_q[7], 3'h0, portb_q[3:1], b_data_q};
  wire [7:0] portc_view = {portc_q[7:1], a_data_q};
  wire [7:0] rd_mux =
    hit(reg_addr_in, `DFR_OFF_PORTB) ? portb_view :
    hit(reg_addr_in, `DFR_OFF_PORTC) ? portc_view :
    hit(reg_addr_in, `DFR_OFF_PORTD) ? portd_q :
    hit(reg_addr_in, `DFR_OFF_DIRB) ? dirb_q :
    hit(reg_addr_in, `DFR_OFF_DIRC) ? dirc_q :
    hit(reg_addr_in, `DFR_OFF_DIRD) ? dird_q : 8'h00;

  // selects as wired to the port bits
  wire [2:0] a_sel_pins = {portc_q[`DFR_C_SEL_MSB], portd_q[`DFR_D_SEL_MID],
                           portd_q[`DFR_D_SEL_LSB]};
  wire [2:0] b_sel_pins = {portb_q[`DFR_B_SEL_HI], portb_q[2], portb_q[`DFR_B_SEL_LO]};

  assign a_mode = portd_q[`DFR_D_PWDN] ? DFR_POWERDOWN : DFR_NORMAL;
  assign b_mode = portb_q[`DFR_B_PWDN] ? DFR_POWERDOWN : DFR_NORMAL;

  ////////////////////////////////////////////////////////////////////////////
  // port registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      portb_q <= `DFR_PORT_RST;
      portc_q <= `DFR_PORT_RST;
      portd_q <= `DFR_PORT_RST;
    end else begin
      if (wr_b) portb_q <= reg_wdata_in & `DFR_B_KEEP;
      if (wr_c) portc_q <= reg_wdata_in;
      if (wr_d) portd_q <= reg_wdata_in;
    end
  end

  // direction registers; firmware is expected to clear the control bits
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dirb_q <= `DFR_DIR_RST;
      dirc_q <= `DFR_DIR_RST;
      dird_q <= `DFR_DIR_RST;
    end else begin
      if (wr_db) dirb_q <= reg_wdata_in;
      if (wr_dc) dirc_q <= reg_wdata_in;
      if (wr_dd) dird_q <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver a: select and data frozen while powered down; the freeze reads the
  // stored power-down bit, so the cycle that writes it still takes one last sample
  // and the select follows the pins again one cycle after the bit is cleared
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      a_chan_q <= 3'h0;
      a_data_q <= 1'h0;
    end else if (a_mode == DFR_NORMAL) begin
      a_chan_q <= a_sel_pins;
      a_data_q <= rx_a_demod_in;
    end
  end

  // receiver b: independent of receiver a
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      b_chan_q <= 3'h0;
      b_data_q <= 1'h0;
    end else if (b_mode == DFR_NORMAL) begin
      b_chan_q <= b_sel_pins;
      b_data_q <= rx_b_demod_in;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) rdata_q <= 8'h00;
    else rdata_q <= reg_rd_in ? rd_mux : 8'h00;
  end

  assign reg_rdata_out = rdata_q;
  assign rx_a_chan_out = a_chan_q;
  assign rx_b_chan_out = b_chan_q;
  assign rx_a_powerdown_out = portd_q[`DFR_D_PWDN];
  assign rx_b_powerdown_out = portb_q[`DFR_B_PWDN];
  assign rx_a_demod_out = a_data_q;
  assign rx_b_demod_out = b_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks; antecedents of the disabled checks leave out a sampled reset, because an attempt that starts
  // on the release edge is not disabled and would otherwise meet reset values

  // power-down freeze of both receivers
  a_hold_pd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(rx_a_powerdown_out) |->
      $stable(rx_a_chan_out) && $stable(rx_a_demod_out))
    else $error("receiver a changed while powered down");
  b_hold_pd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(rx_b_powerdown_out) |->
      $stable(rx_b_chan_out) && $stable(rx_b_demod_out))
    else $error("receiver b changed while powered down");

  // power-down bits follow their writes
  a_pwdn_wr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && wr_d |=> rx_a_powerdown_out == $past(reg_wdata_in[0]))
    else $error("receiver a power-down bit not taken");
  b_pwdn_wr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && wr_b |=> rx_b_powerdown_out == $past(reg_wdata_in[7]))
    else $error("receiver b power-down bit not taken");

  // power-down bits hold while their location is not written
  a_pwdn_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !wr_d |=> $stable(rx_a_powerdown_out))
    else $error("receiver a power-down bit moved without a write");
  b_pwdn_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !wr_b |=> $stable(rx_b_powerdown_out))
    else $error("receiver b power-down bit moved without a write");

  // channel codes as wired to the port bits
  a_sel_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !rx_a_powerdown_out ##1 1 |-> rx_a_chan_out == $past(a_sel_pins))
    else $error("receiver a select mismatch");
  b_sel_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !rx_b_powerdown_out ##1 1 |-> rx_b_chan_out == $past(portb_q[3:1]))
    else $error("receiver b select mismatch");

  // each select moves only through its own port writes
  a_chan_indep_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !wr_c && !wr_d ##1 !rst_in && !wr_c && !wr_d |=>
      $stable(rx_a_chan_out))
    else $error("receiver a select moved without a port c or d write");
  b_chan_indep_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !wr_b ##1 !rst_in && !wr_b |=> $stable(rx_b_chan_out))
    else $error("receiver b select moved without a port b write");

  // demodulated data passes in normal mode
  a_data_path_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !rx_a_powerdown_out |=> rx_a_demod_out == $past(rx_a_demod_in))
    else $error("receiver a data not passed");
  b_data_path_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && !rx_b_powerdown_out |=> rx_b_demod_out == $past(rx_b_demod_in))
    else $error("receiver b data not passed");

  // read views of the port locations
  b_data_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && reg_rd_in && hit(reg_addr_in, `DFR_OFF_PORTB) |=>
      reg_rdata_out[0] == $past(rx_b_demod_out) && reg_rdata_out[6:4] == 3'h0)
    else $error("port b read wrong");
  a_data_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && reg_rd_in && hit(reg_addr_in, `DFR_OFF_PORTC) |=>
      reg_rdata_out[0] == $past(rx_a_demod_out))
    else $error("port c read wrong");
  b_sel_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && reg_rd_in && hit(reg_addr_in, `DFR_OFF_PORTB) |=>
      reg_rdata_out[3:1] == $past(portb_q[3:1]) &&
      reg_rdata_out[7] == $past(rx_b_powerdown_out))
    else $error("port b control bits read wrong");
  a_pwdn_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rst_in && reg_rd_in && hit(reg_addr_in, `DFR_OFF_PORTD) |=>
      reg_rdata_out[`DFR_D_PWDN] == $past(rx_a_powerdown_out))
    else $error("port d power-down bit read wrong");

  // reset leaves both receivers in normal mode and the read data clear
  pd_reset_a: assert property (@(posedge sys_clk_in)
    rst_in |=> !rx_a_powerdown_out && !rx_b_powerdown_out && reg_rdata_out == 8'h00)
    else $error("outputs not cleared by reset");
endmodule : dfr_receiver_ctrl

// ---- sim/dfr_receiver_ctrl_test.sv ----
/*
 self-checking bench of the dual receiver control block, with a model of the ports.
 assumes the bench drives the register port and the receiver data pins itself.
*/
`timescale 1ns/1ps
`include "dfr_consts.svh"
module dfr_receiver_ctrl_test;
  import dfr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, da = 1'b0, db = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h00, rdat, v, ev;
  logic [2:0] cha, chb, a;
  logic pda, pdb, oda, odb;
  logic [2:0] ea = 3'h0, eb = 3'h0;
  logic ena = 1'b0, enb = 1'b0;
  int n_fail = 0, n_checks = 0;
  int m [6];
  logic [7:0] mk [7] = '{8'h8e, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  dfr_receiver_ctrl dut_u (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(adr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .rx_a_demod_in(da), .rx_b_demod_in(db), .rx_a_chan_out(cha), .rx_b_chan_out(chb),
    .rx_a_powerdown_out(pda), .rx_b_powerdown_out(pdb), .rx_a_demod_out(oda),
    .rx_b_demod_out(odb));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, compare, verdict
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  // register port cycles; unmapped writes leave the model alone
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    adr <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (ad < 6) m[ad] = d;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    adr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask : rd_reg
  // new random demod data, settle, then compare outputs and every location
  task automatic check_all;
    da <= 1'($urandom);
    db <= 1'($urandom);
    repeat (3) @(posedge clk);
    if (!m[2][0]) begin
      ea = {m[1][3], m[2][4], m[2][5]};
      ena = da;
    end
    if (!m[0][7]) begin
      eb = m[0][3:1];
      enb = db;
    end
    #1;
    chk({5'h0, cha}, {5'h0, ea}, "chan a");
    chk({5'h0, chb}, {5'h0, eb}, "chan b");
    chk({6'h0, pda, pdb}, {6'h0, m[2][0], m[0][7]}, "powerdown");
    chk({6'h0, oda, odb}, {6'h0, ena, enb}, "demod");
    for (int i = 0; i < 7; i++) begin
      rd_reg(i < 6 ? 4'(i) : 4'h9, v);
      ev = i == 6 ? 8'h00 : 8'(m[i]) & mk[i];
      ev[0] = ev[0] | (i == 0 ? enb : i == 1 ? ena : 1'b0);
      chk(v, ev, "readback");
    end
  endtask : check_all
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #40000;
    n_fail++;
    tally_and_finish();
  end
  // tests
  initial begin
    void'($urandom(32'h8d2432ac));
    m = '{0, 0, 0, 255, 255, 255};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    check_all();
    $display("test reset done");
    wr_reg(`DFR_OFF_DIRB, 8'h00);
    wr_reg(`DFR_OFF_DIRC, 8'h00);
    wr_reg(`DFR_OFF_DIRD, 8'h00);
    for (int c = 0; c < `DFR_CHAN_COUNT; c++) begin
      v = 8'($urandom);
      a = ~3'(c);
      wr_reg(`DFR_OFF_PORTB, {1'b0, v[6:4], 3'(c), v[0]});
      wr_reg(`DFR_OFF_PORTC, {v[7:4], a[2], v[2:0]});
      wr_reg(`DFR_OFF_PORTD, {v[7:6], a[0], a[1], v[3:1], 1'b0});
      wr_reg(4'hc, 8'hff);
      check_all();
    end
    $display("test channels done");
    wr_reg(`DFR_OFF_PORTD, 8'(m[2]) | 8'h01);
    wr_reg(`DFR_OFF_PORTB, 8'(m[0]) | 8'h80);
    check_all();
    wr_reg(`DFR_OFF_PORTC, 8'(m[1]) ^ 8'h08);
    wr_reg(`DFR_OFF_PORTB, 8'(m[0]) ^ 8'h0e);
    check_all();
    wr_reg(`DFR_OFF_PORTD, 8'(m[2]) & 8'hfe);
    wr_reg(`DFR_OFF_PORTB, 8'(m[0]) & 8'h7f);
    check_all();
    $display("test powerdown done");
    // mid-run reset: outputs clear while held, locations return to reset values
    @(posedge clk);
    da <= 1'b1;
    db <= 1'b1;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({cha, chb, pda, pdb}, 8'h00, "reset select");
    chk({6'h0, oda, odb}, 8'h00, "reset data");
    @(posedge clk);
    rst <= 1'b0;
    m = '{0, 0, 0, 255, 255, 255};
    check_all();
    $display("test midreset done");
    tally_and_finish();
  end
endmodule : dfr_receiver_ctrl_test
